// ---- common/mffr_pkg.sv ----
// package: offsets, field positions and carriers of the fault flag bank
package mffr_pkg;
  localparam int         REG_W         = 16;
  localparam int         ADDR_W        = 8;
  localparam int         CELLS         = 16;
  localparam int         AUX_CH        = 8;
  localparam int         SYS_ANALOG_W  = 4;
  // byte offsets of the 16-bit registers on the command interface
  localparam logic [7:0] OFS_SUMMARY   = 8'h52;
  localparam logic [7:0] OFS_CELL_LOW  = 8'h54;
  localparam logic [7:0] OFS_CELL_HIGH = 8'h56;
  localparam logic [7:0] OFS_AUX       = 8'h58;
  localparam logic [7:0] OFS_CMP_LOW   = 8'h5A;
  localparam logic [7:0] OFS_CMP_HIGH  = 8'h5C;
  localparam logic [7:0] OFS_LINK      = 8'h5E;
  // field positions
  localparam int         AUX_LOW_LSB   = 8;
  localparam int         AUX_HIGH_LSB  = 0;
  localparam int         LINK_UP_ERR   = 15;
  localparam int         LINK_LO_ERR   = 14;
  localparam int         LINK_UP_ABORT = 13;
  localparam int         LINK_LO_ABORT = 12;
  localparam int         SUM_CELL_LOW  = 15;
  localparam int         SUM_CELL_HIGH = 14;
  localparam int         SUM_AUX_LOW   = 13;
  localparam int         SUM_AUX_HIGH  = 12;
  localparam int         SUM_CMP_LOW   = 11;
  localparam int         SUM_CMP_HIGH  = 10;
  localparam int         SUM_LINK      = 9;
  // reset values and abort mismatch count
  localparam logic [15:0] FLAGS_RESET  = 16'h0000;
  localparam logic [1:0]  ERR_CNT_RESET = 2'h0;
  localparam logic [1:0]  ABORT_COUNT   = 2'h2;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } mffr_reg_req_t;

  typedef struct packed {
    logic        valid;
    logic        is_aux;
    logic [3:0]  chan;
    logic [15:0] value;
  } mffr_result_t;

  typedef struct packed {
    logic frame_start;
    logic frame_end;
    logic bit_valid;
    logic bit_val;
    logic bit_cmp;
  } mffr_link_rx_t;

  typedef enum logic [2:0] {
    LNK_IDLE    = 3'b001,
    LNK_FRAME   = 3'b010,
    LNK_STOPPED = 3'b100
  } mffr_link_state_t;
endpackage

// ---- src/mffr_flag_bank.sv ----
// one 16-bit write-one-to-clear flag register with optional self-clearing
`timescale 1ns/100ps
module mffr_flag_bank
  import mffr_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              srst,
  input  wire logic [REG_W-1:0]  set,
  input  wire logic [REG_W-1:0]  cond,
  input  wire logic [REG_W-1:0]  clr,
  input  wire logic              auto_clr_en,
  output logic      [REG_W-1:0]  flags
);
  wire logic [REG_W-1:0] auto_clr;
  wire logic [REG_W-1:0] next_flags;

  // condition gone and self-clearing allowed
  assign auto_clr   = auto_clr_en ? ~cond : {REG_W{1'b0}};
  // set wins over both kinds of clear
  assign next_flags = (flags & ~clr & ~auto_clr) | set;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      flags <= FLAGS_RESET;
    end else begin
      flags <= next_flags;
    end
  end
endmodule // mffr_flag_bank

// ---- src/mffr_link_check.sv ----
// complement check and frame stop for one daisy-chain receive port
`timescale 1ns/100ps
module mffr_link_check
  import mffr_pkg::*;
(
  input  wire logic          sys_clk,
  input  wire logic          srst,
  input  wire mffr_link_rx_t rx,
  output logic               comp_err,
  output logic               frame_abort,
  output logic               frame_stop
);
  mffr_link_state_t state;
  mffr_link_state_t next_state;
  logic [1:0]       err_cnt;

  wire logic mismatch;
  wire logic checking;
  wire logic abort_now;

  assign checking  = (state == LNK_FRAME) && rx.bit_valid;
  // a good bit arrives together with its inverse
  assign mismatch  = checking && (rx.bit_val == rx.bit_cmp);
  assign abort_now = mismatch && (err_cnt == ABORT_COUNT - 2'h1);

  always_comb begin
    next_state = state;
    case (state)
      LNK_IDLE:    if (rx.frame_start) next_state = LNK_FRAME;
      LNK_FRAME: begin
        if (rx.frame_end) next_state = LNK_IDLE;
        else if (abort_now) next_state = LNK_STOPPED;
      end
      LNK_STOPPED: if (rx.frame_end) next_state = LNK_IDLE;
      default:     next_state = LNK_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state       <= LNK_IDLE;
      err_cnt     <= ERR_CNT_RESET;
      comp_err    <= 1'b0;
      frame_abort <= 1'b0;
      frame_stop  <= 1'b0;
    end else begin
      state       <= next_state;
      err_cnt     <= (state == LNK_IDLE) ? ERR_CNT_RESET
                   : err_cnt + {1'b0, mismatch};
      comp_err    <= mismatch;
      frame_abort <= abort_now;
      frame_stop  <= (next_state == LNK_STOPPED);
    end
  end

  // stopped frames ignore the rest of their bits until the frame ends
  chk_second_error_stops: assert property (@(posedge sys_clk)
    disable iff (srst) abort_now |=> frame_abort && frame_stop)
    else $error("second mismatch did not stop the frame");
endmodule // mffr_link_check

// ---- src/mffr_fault_flags.sv ----
// fault flag register group: cell, aux, comparator and link error flags
`timescale 1ns/100ps
module mffr_fault_flags
  import mffr_pkg::*;
(
  input  wire logic                                sys_clk,
  input  wire logic                                srst,
  input  wire mffr_pkg::mffr_reg_req_t             reg_req,
  output logic [mffr_pkg::REG_W-1:0]               reg_rdata,
  output logic                                     reg_rvalid,
  input  wire logic                                self_clear_mode,
  input  wire mffr_pkg::mffr_result_t              result,
  input  wire logic [15:0]                         cell_low_threshold,
  input  wire logic [15:0]                         cell_high_threshold,
  input  wire logic [7:0][15:0]                    aux_low_threshold,
  input  wire logic [7:0][15:0]                    aux_high_threshold,
  input  wire logic [mffr_pkg::CELLS-1:0]          comparator_low_in,
  input  wire logic [mffr_pkg::CELLS-1:0]          comparator_high_in,
  input  wire logic [mffr_pkg::SYS_ANALOG_W-1:0]   system_fault_flags,
  input  wire mffr_pkg::mffr_link_rx_t             upper_chain_port,
  input  wire mffr_pkg::mffr_link_rx_t             lower_chain_port,
  output logic                                     upper_frame_stop,
  output logic                                     lower_frame_stop
);
  import mffr_pkg::*;

  // write-one-to-clear mask for one register offset
  function automatic logic [REG_W-1:0] w1c(input mffr_reg_req_t req,
                                           input logic [7:0] ofs);
    w1c = (req.wr && req.addr == ofs) ? req.wdata : {REG_W{1'b0}};
  endfunction

  // whole-type clear from a one written to a summary bit
  function automatic logic [REG_W-1:0] sum_clr(input mffr_reg_req_t req,
                                               input int bitpos);
    sum_clr = (req.wr && req.addr == OFS_SUMMARY && req.wdata[bitpos])
            ? {REG_W{1'b1}} : {REG_W{1'b0}};
  endfunction

  logic [REG_W-1:0] cell_low_voltage_flags;
  logic [REG_W-1:0] cell_high_voltage_flags;
  logic [REG_W-1:0] aux_threshold_flags;
  logic [REG_W-1:0] comparator_low_flags;
  logic [REG_W-1:0] comparator_high_flags;
  logic [REG_W-1:0] link_error_flags;

  // latest comparison of each stored result
  logic [CELLS-1:0]  cell_low_cond;
  logic [CELLS-1:0]  cell_high_cond;
  logic [AUX_CH-1:0] aux_low_cond;
  logic [AUX_CH-1:0] aux_high_cond;

  // analog-die comparator outputs are asynchronous to sys_clk
  logic [CELLS-1:0] cmp_low_meta;
  logic [CELLS-1:0] cmp_low_s;
  logic [CELLS-1:0] cmp_high_meta;
  logic [CELLS-1:0] cmp_high_s;

  wire logic [15:0] aux_lo_thr;
  wire logic [15:0] aux_hi_thr;
  wire logic        cell_hit;
  wire logic        aux_hit;
  wire logic [15:0] chan_onehot;
  wire logic        below_cell;
  wire logic        above_cell;
  wire logic        below_aux;
  wire logic        above_aux;

  assign chan_onehot = 16'h0001 << result.chan;
  assign cell_hit    = result.valid && !result.is_aux;
  assign aux_hit     = result.valid && result.is_aux && !result.chan[3];
  assign aux_lo_thr  = aux_low_threshold[result.chan[2:0]];
  assign aux_hi_thr  = aux_high_threshold[result.chan[2:0]];
  assign below_cell  = result.value < cell_low_threshold;
  assign above_cell  = result.value > cell_high_threshold;
  assign below_aux   = result.value < aux_lo_thr;
  assign above_aux   = result.value > aux_hi_thr;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cell_low_cond  <= '0;
      cell_high_cond <= '0;
      aux_low_cond   <= '0;
      aux_high_cond  <= '0;
    end else begin
      if (cell_hit) begin
        cell_low_cond  <= below_cell ? (cell_low_cond | chan_onehot)
                                     : (cell_low_cond & ~chan_onehot);
        cell_high_cond <= above_cell ? (cell_high_cond | chan_onehot)
                                     : (cell_high_cond & ~chan_onehot);
      end
      if (aux_hit) begin
        aux_low_cond  <= below_aux ? (aux_low_cond | chan_onehot[7:0])
                                   : (aux_low_cond & ~chan_onehot[7:0]);
        aux_high_cond <= above_aux ? (aux_high_cond | chan_onehot[7:0])
                                   : (aux_high_cond & ~chan_onehot[7:0]);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cmp_low_meta  <= '0;
      cmp_low_s     <= '0;
      cmp_high_meta <= '0;
      cmp_high_s    <= '0;
    end else begin
      cmp_low_meta  <= comparator_low_in;
      cmp_low_s     <= cmp_low_meta;
      cmp_high_meta <= comparator_high_in;
      cmp_high_s    <= cmp_high_meta;
    end
  end

  // link checkers
  logic up_err;
  logic up_abort;
  logic lo_err;
  logic lo_abort;

  mffr_link_check u_upper (
    .sys_clk     (sys_clk),
    .srst        (srst),
    .rx          (upper_chain_port),
    .comp_err    (up_err),
    .frame_abort (up_abort),
    .frame_stop  (upper_frame_stop)
  );

  mffr_link_check u_lower (
    .sys_clk     (sys_clk),
    .srst        (srst),
    .rx          (lower_chain_port),
    .comp_err    (lo_err),
    .frame_abort (lo_abort),
    .frame_stop  (lower_frame_stop)
  );

  // clears from register writes and summary writes
  wire logic [REG_W-1:0] clr_cell_low;
  wire logic [REG_W-1:0] clr_cell_high;
  wire logic [REG_W-1:0] clr_aux;
  wire logic [REG_W-1:0] clr_cmp_low;
  wire logic [REG_W-1:0] clr_cmp_high;
  wire logic [REG_W-1:0] clr_link;

  assign clr_cell_low  = w1c(reg_req, OFS_CELL_LOW)
                       | sum_clr(reg_req, SUM_CELL_LOW);
  assign clr_cell_high = w1c(reg_req, OFS_CELL_HIGH)
                       | sum_clr(reg_req, SUM_CELL_HIGH);
  assign clr_aux       = w1c(reg_req, OFS_AUX)
                       | (sum_clr(reg_req, SUM_AUX_LOW) & 16'hFF00)
                       | (sum_clr(reg_req, SUM_AUX_HIGH) & 16'h00FF);
  assign clr_cmp_low   = w1c(reg_req, OFS_CMP_LOW)
                       | sum_clr(reg_req, SUM_CMP_LOW);
  assign clr_cmp_high  = w1c(reg_req, OFS_CMP_HIGH)
                       | sum_clr(reg_req, SUM_CMP_HIGH);
  assign clr_link      = w1c(reg_req, OFS_LINK)
                       | sum_clr(reg_req, SUM_LINK);

  // interlock: any analog fault, masked or not, holds every comparator flag against self-clearing
  wire logic analog_busy;
  wire logic cmp_auto_ok;
  wire logic [REG_W-1:0] aux_cond;
  wire logic [REG_W-1:0] link_set;

  assign analog_busy = (|system_fault_flags) | (|cmp_low_s)
                     | (|cmp_high_s);
  assign cmp_auto_ok = self_clear_mode && !analog_busy;
  assign aux_cond    = {aux_low_cond, aux_high_cond};
  assign link_set    = {up_err, lo_err, up_abort, lo_abort,
                        12'h000};

  mffr_flag_bank u_cell_low (
    .sys_clk     (sys_clk),
    .srst        (srst),
    .set         (cell_low_cond),
    .cond        (cell_low_cond),
    .clr         (clr_cell_low),
    .auto_clr_en (self_clear_mode),
    .flags       (cell_low_voltage_flags)
  );

  mffr_flag_bank u_cell_high (
    .sys_clk     (sys_clk),
    .srst        (srst),
    .set         (cell_high_cond),
    .cond        (cell_high_cond),
    .clr         (clr_cell_high),
    .auto_clr_en (self_clear_mode),
    .flags       (cell_high_voltage_flags)
  );

  mffr_flag_bank u_aux (
    .sys_clk     (sys_clk),
    .srst        (srst),
    .set         (aux_cond),
    .cond        (aux_cond),
    .clr         (clr_aux),
    .auto_clr_en (self_clear_mode),
    .flags       (aux_threshold_flags)
  );

  mffr_flag_bank u_cmp_low (
    .sys_clk     (sys_clk),
    .srst        (srst),
    .set         (cmp_low_s),
    .cond        (cmp_low_s),
    .clr         (clr_cmp_low),
    .auto_clr_en (cmp_auto_ok),
    .flags       (comparator_low_flags)
  );

  mffr_flag_bank u_cmp_high (
    .sys_clk     (sys_clk),
    .srst        (srst),
    .set         (cmp_high_s),
    .cond        (cmp_high_s),
    .clr         (clr_cmp_high),
    .auto_clr_en (cmp_auto_ok),
    .flags       (comparator_high_flags)
  );

  // link errors are events, never self-clearing
  mffr_flag_bank u_link (
    .sys_clk     (sys_clk),
    .srst        (srst),
    .set         (link_set),
    .cond        (16'h0000),
    .clr         (clr_link),
    .auto_clr_en (1'b0),
    .flags       (link_error_flags)
  );

  // read path; summary follows current flags, latched or not
  wire logic [REG_W-1:0] summary;
  wire logic [REG_W-1:0] read_mux;

  assign summary = {|cell_low_voltage_flags,
                    |cell_high_voltage_flags,
                    |aux_threshold_flags[15:8],
                    |aux_threshold_flags[7:0],
                    |comparator_low_flags,
                    |comparator_high_flags,
                    |link_error_flags,
                    9'h000};
  assign read_mux =
      (reg_req.addr == OFS_SUMMARY)   ? summary :
      (reg_req.addr == OFS_CELL_LOW)  ? cell_low_voltage_flags :
      (reg_req.addr == OFS_CELL_HIGH) ? cell_high_voltage_flags :
      (reg_req.addr == OFS_AUX)       ? aux_threshold_flags :
      (reg_req.addr == OFS_CMP_LOW)   ? comparator_low_flags :
      (reg_req.addr == OFS_CMP_HIGH)  ? comparator_high_flags :
      (reg_req.addr == OFS_LINK)      ? link_error_flags :
      16'h0000;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reg_rdata  <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rdata  <= reg_req.rd ? read_mux : 16'h0000;
      reg_rvalid <= reg_req.rd;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  chk_cell_low_set: assert property (
    cell_hit && below_cell |-> ##2
      cell_low_voltage_flags[$past(result.chan, 2)])
    else $error("cell low flag not set");

  chk_cell_high_set: assert property (
    cell_hit && above_cell |-> ##2
      cell_high_voltage_flags[$past(result.chan, 2)])
    else $error("cell high flag not set");

  chk_zero_write_keeps: assert property (
    reg_req.wr && reg_req.addr == OFS_LINK && reg_req.wdata == 16'h0000
      && link_set == 16'h0000 |=> $stable(link_error_flags))
    else $error("zero write changed link flags");

  chk_self_clear_cell: assert property (
    self_clear_mode
      |=> (cell_low_voltage_flags & ~$past(cell_low_cond)) == 16'h0000)
    else $error("cell flag did not self-clear");

  chk_aux_low_set: assert property (
    aux_hit && below_aux |-> ##2
      aux_threshold_flags[AUX_LOW_LSB + $past(result.chan[2:0], 2)])
    else $error("aux low flag not set");

  chk_aux_high_set: assert property (
    aux_hit && above_aux |-> ##2
      aux_threshold_flags[$past(result.chan[2:0], 2)])
    else $error("aux high flag not set");

  chk_cmp_low_set: assert property (
    |cmp_low_s |=> (comparator_low_flags & $past(cmp_low_s))
      == $past(cmp_low_s))
    else $error("comparator low flag not set");

  chk_cmp_high_set: assert property (
    |cmp_high_s |=> (comparator_high_flags & $past(cmp_high_s))
      == $past(cmp_high_s))
    else $error("comparator high flag not set");

  chk_cmp_interlock: assert property (
    (|system_fault_flags) && clr_cmp_low == 16'h0000
      |=> (comparator_low_flags & $past(comparator_low_flags))
        == $past(comparator_low_flags))
    else $error("comparator flag cleared under analog fault");

  chk_upper_err_flag: assert property (
    up_err |=> link_error_flags[LINK_UP_ERR])
    else $error("upper mismatch not recorded");

  chk_lower_err_flag: assert property (
    lo_err |=> link_error_flags[LINK_LO_ERR])
    else $error("lower mismatch not recorded");

  chk_upper_abort_flag: assert property (
    up_abort |=> link_error_flags[LINK_UP_ABORT] && upper_frame_stop)
    else $error("upper abort not recorded");

  chk_lower_abort_flag: assert property (
    lo_abort |=> link_error_flags[LINK_LO_ABORT] && lower_frame_stop)
    else $error("lower abort not recorded");

  chk_summary_follows: assert property (
    reg_req.rd && reg_req.addr == OFS_SUMMARY
      |=> reg_rdata[SUM_CELL_LOW] == $past(|cell_low_voltage_flags))
    else $error("summary bit wrong");

  chk_reset_clean: assert property (
    @(posedge sys_clk) disable iff (1'b0)
    $past(srst) |-> link_error_flags == 16'h0000
      && cell_low_voltage_flags == 16'h0000 && reg_rdata == 16'h0000)
    else $error("flags not zero after reset");
endmodule // mffr_fault_flags

// ---- dv/mffr_host_model.sv ----
// host side model: register reads and clears over the command link
`timescale 1ns/100ps
module mffr_host_model (
  input  wire logic               sys_clk,
  output mffr_pkg::mffr_reg_req_t reg_req,
  input  wire logic [15:0]        reg_rdata,
  input  wire logic               reg_rvalid
);
  import mffr_pkg::*;

  initial reg_req = '0;

  // released lines flip so a stale address never looks valid
  task automatic idle();
    reg_req.wr    = 1'b0;
    reg_req.rd    = 1'b0;
    reg_req.addr  = ~reg_req.addr;
    reg_req.wdata = ~reg_req.wdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    #1;
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk);
    #1;
    idle();
  endtask

  // answer expected one edge after the strobe, nothing waits longer
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    #1;
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge sys_clk);
    #1;
    d = (reg_rvalid === 1'b1) ? reg_rdata : 16'hXXXX;
    idle();
  endtask
endmodule // mffr_host_model

// ---- dv/tb.sv ----
// testbench: fault flag bank driven through the host model
`timescale 1ns/100ps
module tb;
  import mffr_pkg::*;
  typedef struct packed {
    logic        aux;
    logic [3:0]  ch;
    logic [15:0] v;
    logic [7:0]  ofs;
    logic [15:0] e;
  } mffr_row_t;
  logic             sys_clk;
  logic             srst;
  mffr_reg_req_t    reg_req;
  logic [15:0]      rdata;
  logic             rvalid;
  logic             scm;
  mffr_result_t     result;
  logic [15:0]      c_lo;
  logic [15:0]      c_hi;
  logic [7:0][15:0] a_lo;
  logic [7:0][15:0] a_hi;
  logic [15:0]      k_lo;
  logic [15:0]      k_hi;
  logic [3:0]       sys_flt;
  mffr_link_rx_t    up_rx;
  mffr_link_rx_t    lo_rx;
  logic             up_stop;
  logic             lo_stop;
  logic             s0;
  logic             s1;
  int               failures;
  int               checked;
  mffr_row_t        rows [4];

  mffr_fault_flags u_dut (
    .sys_clk             (sys_clk),
    .srst                (srst),
    .reg_req             (reg_req),
    .reg_rdata           (rdata),
    .reg_rvalid          (rvalid),
    .self_clear_mode     (scm),
    .result              (result),
    .cell_low_threshold  (c_lo),
    .cell_high_threshold (c_hi),
    .aux_low_threshold   (a_lo),
    .aux_high_threshold  (a_hi),
    .comparator_low_in   (k_lo),
    .comparator_high_in  (k_hi),
    .system_fault_flags  (sys_flt),
    .upper_chain_port    (up_rx),
    .lower_chain_port    (lo_rx),
    .upper_frame_stop    (up_stop),
    .lower_frame_stop    (lo_stop)
  );

  mffr_host_model u_host (
    .sys_clk    (sys_clk),
    .reg_req    (reg_req),
    .reg_rdata  (rdata),
    .reg_rvalid (rvalid)
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    checked = checked + 1;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      failures = failures + 1;
    end
  endtask

  task automatic rchk(input string n, input logic [7:0] a,
                      input logic [15:0] e);
    logic [15:0] d;
    u_host.rd(a, d);
    chk(n, e, d);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic res(input logic aux, input logic [3:0] ch,
                     input logic [15:0] v);
    tick(1);
    result = '{valid: 1'b1, is_aux: aux, chan: ch, value: v};
    tick(1);
    result.valid = 1'b0;
    tick(2);
  endtask

  task automatic drv(input logic lo, input mffr_link_rx_t r);
    tick(1);
    if (lo) lo_rx = r;
    else up_rx = r;
  endtask

  // frame of three bits, the first bad ones repeat their value in place of its complement
  task automatic link(input logic lo, input int bad,
                      output logic st, output logic after);
    mffr_link_rx_t r;
    r = '0;
    r.frame_start = 1'b1;
    drv(lo, r);
    for (int i = 0; i < 3; i++) begin
      r = '0;
      r.bit_valid = 1'b1;
      r.bit_val = 1'b1;
      r.bit_cmp = (i < bad);
      drv(lo, r);
    end
    r = '0;
    r.frame_end = 1'b1;
    drv(lo, r);
    st = lo ? lo_stop : up_stop;
    drv(lo, '0);
    drv(lo, '0);
    after = lo ? lo_stop : up_stop;
  endtask

  task automatic test_done();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    failures = failures + 1;
    $display("ERROR watchdog expected done seen running");
    test_done();
  end

  initial begin
    srst = 1'b1;
    scm = 1'b0;
    result = '0;
    c_lo = 16'h1000;
    c_hi = 16'h3000;
    a_lo = {8{16'h0100}};
    a_hi = {8{16'h0F00}};
    k_lo = 16'h0000;
    k_hi = 16'h0000;
    sys_flt = 4'h0;
    up_rx = '0;
    lo_rx = '0;
    failures = 0;
    checked = 0;
    rows[0] = '{1'b0, 4'h0, 16'h0800, OFS_CELL_LOW, 16'h0001};
    rows[1] = '{1'b0, 4'hF, 16'h3800, OFS_CELL_HIGH, 16'h8000};
    rows[2] = '{1'b1, 4'h0, 16'h0080, OFS_AUX, 16'h0100};
    rows[3] = '{1'b1, 4'h7, 16'h0F80, OFS_AUX, 16'h0080};
    tick(10);
    srst = 1'b0;
    for (int a = 'h52; a <= 'h60; a += 2) begin
      rchk("reset", a[7:0], 16'h0000);
    end
    rchk("odd", 8'h55, 16'h0000);
    $display("test reset done");
    foreach (rows[i]) begin
      res(rows[i].aux, rows[i].ch, rows[i].v);
      rchk("set", rows[i].ofs, rows[i].e);
      res(rows[i].aux, rows[i].ch, rows[i].aux ? 16'h0800 : 16'h2000);
      u_host.wr(rows[i].ofs, 16'h0000);
      rchk("held", rows[i].ofs, rows[i].e);
      u_host.wr(rows[i].ofs, rows[i].e);
      rchk("clear", rows[i].ofs, 16'h0000);
    end
    res(1'b1, 4'h9, 16'h0000);
    rchk("aux9", OFS_AUX, 16'h0000);
    $display("test table done");
    res(1'b0, 4'h5, 16'h0100);
    rchk("summary", OFS_SUMMARY, 16'h8000);
    res(1'b0, 4'h5, 16'h2000);
    u_host.wr(OFS_SUMMARY, 16'h8000);
    rchk("type", OFS_CELL_LOW, 16'h0000);
    scm = 1'b1;
    res(1'b0, 4'h3, 16'h0100);
    rchk("self", OFS_CELL_LOW, 16'h0008);
    res(1'b0, 4'h3, 16'h2000);
    rchk("self", OFS_CELL_LOW, 16'h0000);
    $display("test summary and self clear done");
    sys_flt = 4'h1;
    k_lo[2] = 1'b1;
    k_hi[4] = 1'b1;
    tick(5);
    rchk("cmp lo", OFS_CMP_LOW, 16'h0004);
    rchk("cmp hi", OFS_CMP_HIGH, 16'h0010);
    k_lo[2] = 1'b0;
    tick(5);
    rchk("cmp lo", OFS_CMP_LOW, 16'h0004);
    k_hi[4] = 1'b0;
    tick(5);
    rchk("cmp hi", OFS_CMP_HIGH, 16'h0010);
    sys_flt = 4'h0;
    tick(5);
    rchk("cmp lo", OFS_CMP_LOW, 16'h0000);
    rchk("cmp hi", OFS_CMP_HIGH, 16'h0000);
    scm = 1'b0;
    $display("test comparators done");
    link(1'b0, 2, s0, s1);
    chk("up stop", {15'h0, s0}, 16'h0001);
    chk("up end", {15'h0, s1}, 16'h0000);
    rchk("link", OFS_LINK, 16'hA000);
    u_host.wr(OFS_LINK, 16'hA000);
    rchk("link", OFS_LINK, 16'h0000);
    link(1'b1, 1, s0, s1);
    chk("lo stop", {15'h0, s0}, 16'h0000);
    rchk("link", OFS_LINK, 16'h4000);
    link(1'b1, 2, s0, s1);
    chk("lo stop", {15'h0, s0}, 16'h0001);
    rchk("link", OFS_LINK, 16'h5000);
    u_host.wr(OFS_LINK, 16'h0000);
    rchk("link held", OFS_LINK, 16'h5000);
    $display("test link done");
    test_done();
  end
endmodule // tb
